// *** lcs_defs.vh ***
// Constants for the charger state sequencer: state codes, target scaling and timing counts.
// Assumes a 100 MHz clock and a slow timebase tick from lcs_tick.
`ifndef LCS_DEFS_VH
`define LCS_DEFS_VH
`define LCS_ST_DISABLED 4'h0
`define LCS_ST_DEAD_BATT 4'h1
`define LCS_ST_DEAD_PQ 4'h2
`define LCS_ST_PREQUAL 4'h3
`define LCS_ST_FAST_CC 4'h4
`define LCS_ST_FAST_CV 4'h5
`define LCS_ST_TOPOFF 4'h6
`define LCS_ST_DONE 4'h7
`define LCS_ST_TIMER_FAULT 4'h8
`define LCS_CLK_MHZ 100
`define LCS_SOFT_START_US 1500
`define LCS_SOFT_START_CYCLES (`LCS_SOFT_START_US * `LCS_CLK_MHZ)
`define LCS_TICK_CYCLES 100000
`define LCS_PREQUAL_TICKS 1800000
`define LCS_FAST_CHARGE_TICKS 18000000
`define LCS_TOPOFF_TICKS 1800000
`define LCS_TARGET_FULL 8'hff
`define LCS_TARGET_HALF_SHIFT 1
`define LCS_TARGET_FOLD_SHIFT 3
`endif

// *** lcs_sync.v ***
// Three-stage synchroniser with agreement filter for one asynchronous level.
// Assumes the input is a slow comparator level from the analog side.
`timescale 1ns/1ps
module lcs_sync #(
   parameter RESET_VAL = 1'b0
) (
   input wire clk,
   input wire reset_n,
   input wire ce,
   input wire din,
   output reg dout
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
         dout <= RESET_VAL;
      end else if (ce) begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // Accept a change only once the last two stages agree
         if (s2_reg == s3_reg) begin
            dout <= s3_reg;
         end
      end
   end
endmodule

// *** lcs_tick.v ***
// Timebase divider producing a one-cycle tick every PERIOD clocks.
// Assumes the clock enable of the parent gates it.
`timescale 1ns/1ps
`include "lcs_defs.vh"
module lcs_tick #(
   parameter PERIOD = `LCS_TICK_CYCLES
) (
   input wire clk,
   input wire reset_n,
   input wire ce,
   output reg tick
);
   reg [31:0] cnt_reg;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= 32'h0;
         tick <= 1'b0;
      end else if (ce) begin
         if (cnt_reg >= PERIOD - 1) begin
            cnt_reg <= 32'h0;
            tick <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 32'h1;
            tick <= 1'b0;
         end
      end
   end
endmodule

// *** lcs_sequencer.v ***
// Charger supervisory state machine: state, charger enables, current target.
// Assumes comparator and temperature flags arrive asynchronously from analog.
`timescale 1ns/1ps
`include "lcs_defs.vh"
module lcs_sequencer #(
   parameter TARGET_W = 8,
   parameter TICK_CYCLES = `LCS_TICK_CYCLES,
   parameter SOFT_START_CYCLES = `LCS_SOFT_START_CYCLES,
   parameter PREQUAL_TICKS = `LCS_PREQUAL_TICKS,
   parameter FAST_CHARGE_TICKS = `LCS_FAST_CHARGE_TICKS,
   parameter TOPOFF_TICKS = `LCS_TOPOFF_TICKS
) (
   input wire clk,
   input wire reset_n,
   input wire ce,
   input wire charger_supply_input,
   input wire above_prequal_low_threshold,
   input wire above_prequal_high_threshold,
   input wire above_dead_batt_threshold,
   input wire at_battery_regulation_voltage,
   input wire below_restart_threshold,
   input wire below_topoff_current_threshold,
   input wire above_topoff_plus_margin,
   input wire die_temp_regulation_point,
   input wire thermal_shutdown,
   input wire thermistor_input_in_range,
   input wire thermistor_input_cool,
   input wire [TARGET_W-1:0] fast_charge_current,
   output reg dead_batt_current_en,
   output reg switcher_en,
   output reg [TARGET_W-1:0] current_target,
   output reg [3:0] charger_state,
   output reg timer_fault
);
   localparam [3:0] ST_DISABLED = `LCS_ST_DISABLED;
   localparam [3:0] ST_DEAD_BATT = `LCS_ST_DEAD_BATT;
   localparam [3:0] ST_DEAD_PQ = `LCS_ST_DEAD_PQ;
   localparam [3:0] ST_PREQUAL = `LCS_ST_PREQUAL;
   localparam [3:0] ST_FAST_CC = `LCS_ST_FAST_CC;
   localparam [3:0] ST_FAST_CV = `LCS_ST_FAST_CV;
   localparam [3:0] ST_TOPOFF = `LCS_ST_TOPOFF;
   localparam [3:0] ST_DONE = `LCS_ST_DONE;
   localparam [3:0] ST_TIMER_FAULT = `LCS_ST_TIMER_FAULT;

   wire supply_ok;
   wire pq_low;
   wire pq_high;
   wire dead_hi;
   wire at_reg;
   wire restart;
   wire i_low;
   wire i_high;
   wire die_hot;
   wire tsd;
   wire thm_ok;
   wire thm_cool;
   wire tick;

   // Every analog level is filtered so a chattering comparator cannot split one decision
   lcs_sync u_s0 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(charger_supply_input), .dout(supply_ok));
   lcs_sync u_s1 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(above_prequal_low_threshold), .dout(pq_low));
   lcs_sync u_s2 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(above_prequal_high_threshold), .dout(pq_high));
   lcs_sync u_s3 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(above_dead_batt_threshold), .dout(dead_hi));
   lcs_sync u_s4 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(at_battery_regulation_voltage), .dout(at_reg));
   lcs_sync u_s5 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(below_restart_threshold), .dout(restart));
   lcs_sync u_s6 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(below_topoff_current_threshold), .dout(i_low));
   lcs_sync u_s7 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(above_topoff_plus_margin), .dout(i_high));
   lcs_sync u_s8 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(die_temp_regulation_point), .dout(die_hot));
   lcs_sync u_s9 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(thermal_shutdown), .dout(tsd));
   lcs_sync u_s10 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(thermistor_input_in_range), .dout(thm_ok));
   lcs_sync u_s11 (.clk(clk), .reset_n(reset_n), .ce(ce), .din(thermistor_input_cool), .dout(thm_cool));

   lcs_tick #(.PERIOD(TICK_CYCLES)) u_tick (.clk(clk), .reset_n(reset_n), .ce(ce), .tick(tick));

   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [31:0] pq_cnt_reg;
   reg [31:0] pq_cnt_next;
   reg [31:0] fc_cnt_reg;
   reg [31:0] fc_cnt_next;
   reg [31:0] to_cnt_reg;
   reg [31:0] to_cnt_next;
   reg [31:0] ramp_cnt_reg;
   reg [31:0] ramp_cnt_next;
   reg pq_exp;
   reg fc_exp;
   reg to_exp;
   reg [TARGET_W-1:0] goal;
   reg [TARGET_W-1:0] ramp_val;
   reg [31:0] ramp_wide;
   reg lin_on;
   reg sw_on;

   // Fast-charge family shares the switcher and current target
   function in_fast;
      input [3:0] s;
      begin
         in_fast = (s == ST_FAST_CC) || (s == ST_FAST_CV) || (s == ST_TOPOFF);
      end
   endfunction

   // suspend while thermistor out of range
   wire run = thm_ok;

   // State transitions
   always @* begin
      state_next = state_reg;
      pq_exp = pq_cnt_reg >= PREQUAL_TICKS;
      fc_exp = fc_cnt_reg >= FAST_CHARGE_TICKS;
      to_exp = to_cnt_reg >= TOPOFF_TICKS;
      case (state_reg)
         ST_DISABLED: begin
            if (supply_ok) begin
               if (pq_high) begin
                  state_next = ST_FAST_CC;
               end else if (dead_hi) begin
                  state_next = ST_PREQUAL;
               end else if (pq_low) begin
                  state_next = ST_DEAD_PQ;
               end else begin
                  state_next = ST_DEAD_BATT;
               end
            end
         end
         ST_DEAD_BATT: begin
            if (pq_low) begin
               state_next = ST_DEAD_PQ;
            end
         end
         ST_DEAD_PQ: begin
            if (pq_exp) begin
               state_next = ST_TIMER_FAULT;
            end else if (dead_hi) begin
               state_next = ST_PREQUAL;
            end
         end
         ST_PREQUAL: begin
            if (pq_exp) begin
               state_next = ST_TIMER_FAULT;
            end else if (pq_high) begin
               state_next = ST_FAST_CC;
            end
         end
         ST_FAST_CC: begin
            if (fc_exp) begin
               state_next = ST_TIMER_FAULT;
            end else if (at_reg) begin
               state_next = ST_FAST_CV;
            end
         end
         ST_FAST_CV: begin
            if (fc_exp) begin
               state_next = ST_TIMER_FAULT;
            end else if (i_low) begin
               state_next = ST_TOPOFF;
            end
         end
         ST_TOPOFF: begin
            if (i_high) begin
               state_next = ST_FAST_CV;
            end else if (to_exp) begin
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            if (restart) begin
               state_next = ST_FAST_CC;
            end
         end
         ST_TIMER_FAULT: begin
            state_next = ST_TIMER_FAULT;
         end
         default: begin
            state_next = ST_DISABLED;
         end
      endcase
      if (!run) begin
         state_next = state_reg;
      end
      if (!supply_ok) begin
         state_next = ST_DISABLED;
      end
   end

   // Timers and ramp
   always @* begin
      pq_cnt_next = pq_cnt_reg;
      fc_cnt_next = fc_cnt_reg;
      to_cnt_next = to_cnt_reg;
      ramp_cnt_next = ramp_cnt_reg;
      if (run && tick) begin
         if (state_reg == ST_DEAD_PQ || state_reg == ST_PREQUAL) begin
            pq_cnt_next = pq_cnt_reg + 32'h1;
         end
         // one timer for CC and CV
         if (state_reg == ST_FAST_CC || state_reg == ST_FAST_CV) begin
            fc_cnt_next = fc_cnt_reg + 32'h1;
         end
         if (state_reg == ST_TOPOFF) begin
            to_cnt_next = to_cnt_reg + 32'h1;
         end
      end
      if (state_reg == ST_DEAD_BATT && state_next == ST_DEAD_PQ) begin
         pq_cnt_next = 32'h0;
      end
      // Top-off duration restarts on every entry
      if (state_next != ST_TOPOFF) begin
         to_cnt_next = 32'h0;
      end
      // Fast timer restarts after done or loss of supply
      if (state_next == ST_DISABLED || state_next == ST_DONE) begin
         fc_cnt_next = 32'h0;
      end
      // Prequal timer cleared when supply is lost
      if (state_next == ST_DISABLED) begin
         pq_cnt_next = 32'h0;
      end
      // Ramp counter saturates at the end of soft-start
      if (run && ramp_cnt_reg < SOFT_START_CYCLES) begin
         ramp_cnt_next = ramp_cnt_reg + 32'h1;
      end
      // restart ramp on supply valid or prequal exit to fast CC
      if ((state_reg == ST_DISABLED && state_next != ST_DISABLED) ||
          (state_reg == ST_PREQUAL && state_next == ST_FAST_CC)) begin
         ramp_cnt_next = 32'h0;
      end
      if (state_reg == ST_DONE && state_next == ST_FAST_CC) begin
         ramp_cnt_next = SOFT_START_CYCLES;
      end
   end

   // Enables and target
   always @* begin
      lin_on = (state_next != ST_DISABLED) && (state_next != ST_TIMER_FAULT) && !tsd && !dead_hi;
      // switcher only from dead-battery plus prequal up to top-off, off in done
      sw_on = (state_next == ST_DEAD_PQ) || (state_next == ST_PREQUAL) || in_fast(state_next);
      if (state_next == ST_PREQUAL) begin
         lin_on = 1'b0;
      end
      // suspend output while out of range
      if (!run) begin
         lin_on = 1'b0;
         sw_on = 1'b0;
      end
      goal = fast_charge_current;
      if (thm_cool) begin
         goal = fast_charge_current >> `LCS_TARGET_HALF_SHIFT;
      end
      // Foldback takes precedence; the cool halving is not stacked on it
      // fold back when die hot
      if (die_hot) begin
         goal = fast_charge_current >> `LCS_TARGET_FOLD_SHIFT;
      end
      // Wide quotient so goal times count cannot overflow the target width
      ramp_wide = (goal * ramp_cnt_next) / SOFT_START_CYCLES;
      ramp_val = goal;
      if (ramp_cnt_next < SOFT_START_CYCLES) begin
         ramp_val = ramp_wide[TARGET_W-1:0];
      end
      if (!sw_on) begin
         ramp_val = {TARGET_W{1'b0}};
      end
   end

   // Outputs register the next-state decode so each pin comes from a flip-flop
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ST_DISABLED;
         pq_cnt_reg <= 32'h0;
         fc_cnt_reg <= 32'h0;
         to_cnt_reg <= 32'h0;
         ramp_cnt_reg <= 32'h0;
         dead_batt_current_en <= 1'b0;
         switcher_en <= 1'b0;
         current_target <= {TARGET_W{1'b0}};
         charger_state <= ST_DISABLED;
         timer_fault <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         pq_cnt_reg <= pq_cnt_next;
         fc_cnt_reg <= fc_cnt_next;
         to_cnt_reg <= to_cnt_next;
         ramp_cnt_reg <= ramp_cnt_next;
         dead_batt_current_en <= lin_on;
         switcher_en <= sw_on;
         current_target <= ramp_val;
         charger_state <= state_next;
         timer_fault <= (state_next == ST_TIMER_FAULT);
      end
   end
endmodule

// *** lcs_sequencer_asserts.sv ***
// Concurrent checks on the charger state sequencer outputs.
// Assumes it is bound to lcs_sequencer and sees only its ports.
`timescale 1ns/1ps
`include "lcs_defs.vh"
module lcs_sequencer_asserts #(
   parameter TARGET_W = 8
) (
   input wire clk,
   input wire reset_n,
   input wire ce,
   input wire charger_supply_input,
   input wire dead_batt_current_en,
   input wire switcher_en,
   input wire [TARGET_W-1:0] current_target,
   input wire [3:0] charger_state,
   input wire timer_fault
);
   default clocking cb @(posedge clk); endclocking
   // A frozen clock enable stalls the design, so checks pause with it
   default disable iff (!reset_n || !ce);
   // One cycle after the state left st
   sequence s_left(logic [3:0] st);
      $past(charger_state) == st && charger_state != st;
   endsequence
   // Seven samples allow for the input synchroniser plus the state register
   sequence s_supply_gone;
      !charger_supply_input [*7];
   endsequence
   a_fault_flag_state: assert property (timer_fault == (charger_state == `LCS_ST_TIMER_FAULT))
      else $error("fault flag disagrees with state");
   a_fault_charger_off: assert property (timer_fault |-> !switcher_en && !dead_batt_current_en)
      else $error("charger on in timer fault");
   a_fault_exit_path: assert property (s_left(`LCS_ST_TIMER_FAULT) |-> charger_state == `LCS_ST_DISABLED)
      else $error("timer fault left without supply loss");
   a_supply_drop_off: assert property (s_supply_gone |-> charger_state == `LCS_ST_DISABLED && current_target == 0)
      else $error("not disabled after supply loss");
   a_disabled_all_off: assert property (charger_state == `LCS_ST_DISABLED |-> !switcher_en && !dead_batt_current_en)
      else $error("charger on while disabled");
   a_dead_no_switch: assert property (charger_state == `LCS_ST_DEAD_BATT |-> !switcher_en)
      else $error("switcher on in dead battery");
   a_prequal_no_linear: assert property (charger_state == `LCS_ST_PREQUAL |-> !dead_batt_current_en)
      else $error("linear charger on in prequal");
   a_done_switch_off: assert property (charger_state == `LCS_ST_DONE |-> !switcher_en)
      else $error("switcher on in done");
   a_prequal_exit_path: assert property (s_left(`LCS_ST_PREQUAL) |->
      charger_state inside {`LCS_ST_FAST_CC, `LCS_ST_TIMER_FAULT, `LCS_ST_DISABLED})
      else $error("bad exit from prequal");
   a_done_exit_path: assert property (s_left(`LCS_ST_DONE) |->
      charger_state inside {`LCS_ST_FAST_CC, `LCS_ST_DISABLED})
      else $error("bad exit from done");
   a_topoff_exit_path: assert property (s_left(`LCS_ST_TOPOFF) |->
      charger_state inside {`LCS_ST_DONE, `LCS_ST_FAST_CV, `LCS_ST_DISABLED})
      else $error("bad exit from top-off");
endmodule
bind lcs_sequencer lcs_sequencer_asserts #(.TARGET_W(TARGET_W)) u_chk (.clk(clk), .reset_n(reset_n), .ce(ce),
   .charger_supply_input(charger_supply_input), .dead_batt_current_en(dead_batt_current_en),
   .switcher_en(switcher_en), .current_target(current_target), .charger_state(charger_state),
   .timer_fault(timer_fault));

// *** lcs_batt_model.sv ***
// Analog side model: comparators driven by coarse battery and current codes.
// Assumes the bench sets the codes; current reads zero while the switcher is off.
`timescale 1ns/1ps
module lcs_batt_model (
   input wire [2:0] batt_level,
   input wire [1:0] chg_level,
   input wire switcher_en,
   output wire above_low,
   output wire above_dead,
   output wire above_high,
   output wire at_reg,
   output wire below_restart,
   output wire below_topoff,
   output wire above_margin
);
   // Codes: 0 dead, 1 low to dead, 2 prequal, 3 fast, 4 regulation
   wire [1:0] chg;
   assign above_low = batt_level >= 3'h1;
   assign above_dead = batt_level >= 3'h2;
   assign above_high = batt_level >= 3'h3;
   assign at_reg = batt_level >= 3'h4;
   assign below_restart = batt_level < 3'h4;
   // No switcher, no current: the sensor cannot report current it never sees
   assign chg = switcher_en ? chg_level : 2'h0;
   assign below_topoff = chg == 2'h0;
   assign above_margin = chg == 2'h2;
endmodule

// *** lcs_sequencer_tb.sv ***
// Self-checking bench for the charger state sequencer.
// Assumes lcs_batt_model supplies comparators; timing limits shortened.
`timescale 1ns/1ps
`include "lcs_defs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module lcs_sequencer_tb;
   reg clk = 0, reset_n = 0, ce = 1, supply = 0, dtemp = 0, tsd = 0, in_rng = 1, cool = 0;
   reg [2:0] lvl = 0;
   reg [1:0] cur = 1;
   reg [7:0] fcc = 8'hc8;
   int errors = 0, cmp_count = 0;
   wire lo, dead, hi, at_reg, rst_th, tp_lo, tp_hi, lin_en, sw_en, fault;
   wire [7:0] tgt;
   wire [3:0] st;
   always #5 clk = ~clk;
   lcs_sequencer #(.TICK_CYCLES(4), .SOFT_START_CYCLES(16), .PREQUAL_TICKS(8), .FAST_CHARGE_TICKS(60),
      .TOPOFF_TICKS(6)) dut (.clk(clk), .reset_n(reset_n), .ce(ce), .charger_supply_input(supply),
      .above_prequal_low_threshold(lo), .above_prequal_high_threshold(hi), .above_dead_batt_threshold(dead),
      .at_battery_regulation_voltage(at_reg), .below_restart_threshold(rst_th),
      .below_topoff_current_threshold(tp_lo), .above_topoff_plus_margin(tp_hi),
      .die_temp_regulation_point(dtemp), .thermal_shutdown(tsd), .thermistor_input_in_range(in_rng),
      .thermistor_input_cool(cool), .fast_charge_current(fcc), .dead_batt_current_en(lin_en),
      .switcher_en(sw_en), .current_target(tgt), .charger_state(st), .timer_fault(fault));
   lcs_batt_model model (.batt_level(lvl), .chg_level(cur), .switcher_en(sw_en), .above_low(lo),
      .above_dead(dead), .above_high(hi), .at_reg(at_reg), .below_restart(rst_th), .below_topoff(tp_lo),
      .above_margin(tp_hi));
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bounded wait; a miss ends the run
   task automatic wait_st(input logic [3:0] s, input int lim);
      int n;
      n = 0;
      while (st !== s && n < lim) begin
         @(negedge clk);
         n++;
      end
      settle(2);
      `CHK("state", s, st)
      if (st !== s) close_out();
   endtask
   task automatic power(input logic on, input logic [2:0] l);
      lvl = l;
      supply = on;
      settle(12);
   endtask
   task automatic t_dead_chain;
      power(1, 0);
      wait_st(`LCS_ST_DEAD_BATT, 20);
      `CHK("dead", 2'b10, {lin_en, sw_en})
      lvl = 1;
      wait_st(`LCS_ST_DEAD_PQ, 20);
      `CHK("both", 2'b11, {lin_en, sw_en})
      lvl = 2;
      wait_st(`LCS_ST_PREQUAL, 20);
      `CHK("pq", 2'b01, {lin_en, sw_en})
      lvl = 3;
      wait_st(`LCS_ST_FAST_CC, 20);
      `CHK("ramp", 1'b1, tgt < fcc)
      settle(24);
      `CHK("full", fcc, tgt)
      $display("test dead_chain done");
   endtask
   task automatic t_fold;
      cool = 1;
      settle(10);
      `CHK("cool", fcc >> 1, tgt)
      cool = 0;
      dtemp = 1;
      settle(10);
      `CHK("hot", fcc >> 3, tgt)
      dtemp = 0;
      settle(10);
      `CHK("warm", fcc, tgt)
      $display("test fold done");
   endtask
   task automatic t_cv_topoff;
      lvl = 4;
      wait_st(`LCS_ST_FAST_CV, 20);
      cur = 0;
      wait_st(`LCS_ST_TOPOFF, 20);
      cur = 2;
      wait_st(`LCS_ST_FAST_CV, 20);
      cur = 0;
      wait_st(`LCS_ST_TOPOFF, 20);
      cur = 1;
      wait_st(`LCS_ST_DONE, 60);
      `CHK("done", 1'b0, sw_en)
      lvl = 3;
      wait_st(`LCS_ST_FAST_CC, 20);
      `CHK("no ramp", fcc, tgt)
      $display("test cv_topoff done");
   endtask
   task automatic t_suspend;
      in_rng = 0;
      settle(8);
      `CHK("susp", 2'b00, {lin_en, sw_en})
      settle(300);
      `CHK("no fault", 1'b0, fault)
      in_rng = 1;
      settle(8);
      `CHK("resume", `LCS_ST_FAST_CC, st)
      wait_st(`LCS_ST_TIMER_FAULT, 400);
      `CHK("off", 3'b100, {fault, lin_en, sw_en})
      lvl = 4;
      settle(10);
      `CHK("sticky", `LCS_ST_TIMER_FAULT, st)
      $display("test suspend done");
   endtask
   task automatic t_pq_fault;
      logic [3:0] sts [2] = '{`LCS_ST_DEAD_PQ, `LCS_ST_PREQUAL};
      for (int i = 0; i < 2; i++) begin
         power(0, 0);
         `CHK("cycled", `LCS_ST_DISABLED, st)
         power(1, 3'(i + 1));
         wait_st(sts[i], 20);
         wait_st(`LCS_ST_TIMER_FAULT, 80);
      end
      $display("test pq_fault done");
   endtask
   task automatic t_tsd;
      power(0, 0);
      power(1, 0);
      wait_st(`LCS_ST_DEAD_BATT, 20);
      tsd = 1;
      settle(8);
      `CHK("tsd", 1'b0, lin_en)
      tsd = 0;
      settle(8);
      `CHK("tsd off", 1'b1, lin_en)
      // Frozen clock enable must ignore a supply drop
      ce = 0;
      supply = 0;
      settle(12);
      `CHK("frozen", `LCS_ST_DEAD_BATT, st)
      ce = 1;
      settle(12);
      `CHK("ce back", `LCS_ST_DISABLED, st)
      $display("test tsd done");
   endtask
   initial begin
      settle(2);
      reset_n = 1;
      t_dead_chain();
      t_fold();
      t_cv_topoff();
      t_suspend();
      t_pq_fault();
      t_tsd();
      close_out();
   end
endmodule
